// File: hw/pss_defines.vh
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH
`define PSS_CTRL 8'h00
`define PSS_STATUS 8'h04
`define PSS_SEQ_THR 8'h08
`define PSS_T1 8'h0C
`define PSS_T2 8'h10
`define PSS_T3 8'h14
`define PSS_IRQ_STAT 8'h18
`define PSS_IRQ_MASK 8'h1C
`define PSS_TICK_HZ 100
`define PSS_CLK_HZ 20000000
`define PSS_TICK_CYC (`PSS_CLK_HZ / `PSS_TICK_HZ)
`define PSS_T1_DEF 32'h00000032
`define PSS_T2_DEF 32'h000003E8
`define PSS_T3_DEF 32'h0015F900
`define PSS_POS_THR_DEF 7'h05
`define PSS_NEG_THR_DEF 7'h46
`define PSS_POS_THR_MIN 7'h05
`define PSS_POS_THR_MAX 7'h1E
`define PSS_NEG_THR_MIN 7'h46
`define PSS_NEG_THR_MAX 7'h64
`define PSS_CTRL_GATED 0
`define PSS_CTRL_REMOTE 1
`define PSS_CTRL_TAG_ON 2
`define PSS_CTRL_TAG_OFF 3
`endif

// File: hw/pss_supervision.v
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "pss_defines.vh"
module pss_supervision #(
  parameter TICK_CYC = `PSS_TICK_CYC
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // front panel and mode
  input wire tag_button,
  input wire remote_mode,
  input wire tag_command,
  input wire reclose_block,
  // protection trips
  input wire phase_time_overcurrent,
  input wire earth_time_overcurrent,
  input wire directional_earth_stage_one,
  input wire directional_earth_stage_two,
  // measured quantities, in hundredths of nominal
  input wire [6:0] positive_sequence_voltage,
  input wire [6:0] negative_sequence_voltage,
  input wire sensor_fault,
  input wire voltage_present,
  input wire voltage_absent,
  // protection steering
  output reg hot_line_tag,
  output reg sensitive_settings,
  output reg first_shot_settings,
  output reg reclose_inhibit,
  output reg directional_block,
  output reg protection_block,
  output reg voltage_dependent_reclose_off,
  output reg measurement_enable,
  output reg inverse_rotation,
  output reg direct_rotation,
  // signaling
  output reg overcurrent_signal_output,
  output reg directional_signal_output,
  output reg overcurrent_led,
  output reg directional_led,
  output reg overcurrent_cmd_event,
  output reg directional_cmd_event,
  output wire irq
);
  reg [16:0] s1, s2;
  // every pin level crosses into the clock domain through the same two stages
  wire [16:0] pin = {
    tag_button,
    tag_command,
    phase_time_overcurrent,
    earth_time_overcurrent,
    directional_earth_stage_one,
    directional_earth_stage_two,
    sensor_fault,
    voltage_present,
    voltage_absent,
    reclose_block,
    remote_mode,
    6'h00};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 17'h00000;
      s2 <= 17'h00000;
    end else begin
      s1 <= pin;
      s2 <= s1;
    end
  end
  wire btn = s2[16];
  wire cmd = s2[15];
  wire ptoc = s2[14];
  wire etoc = s2[13];
  wire des1 = s2[12];
  wire des2 = s2[11];
  wire sfault = s2[10];
  wire vpres = s2[9];
  wire vabs = s2[8];
  wire rblk = s2[7];
  wire remote = s2[6];
  // sequence quantities come from the same-clock measurement path
  reg btn_d, cmd_d;
  reg [3:0] ctrl;
  reg [6:0] pos_thr, neg_thr;
  reg [31:0] t1, t2, t3;
  reg [3:0] irq_stat, irq_mask;
  wire wr = psel & penable & pwrite;
  wire rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  function [6:0] clamp;
    input [6:0] v;
    input [6:0] lo;
    input [6:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction
  // tag toggle requests from the path that owns the current mode
  wire loc_req = ~remote & btn & ~btn_d;
  wire sw_on = wr & (paddr == `PSS_CTRL) & pwdata[`PSS_CTRL_TAG_ON];
  wire sw_off = wr & (paddr == `PSS_CTRL) & pwdata[`PSS_CTRL_TAG_OFF];
  wire rem_req = remote & cmd & ~cmd_d;
  wire [3:0] ev;
  // edge history for the two toggle sources
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_d <= 1'b0;
      cmd_d <= 1'b0;
    end else begin
      btn_d <= btn;
      cmd_d <= cmd;
    end
  end
  // a local press toggles; the remote path also has explicit set and clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_line_tag <= 1'b0;
    end else begin
      if (loc_req) begin
        hot_line_tag <= ~hot_line_tag;
      end else if (remote & (sw_on | (rem_req & ~hot_line_tag))) begin
        hot_line_tag <= 1'b1;
      end else if (remote & (sw_off | (rem_req & hot_line_tag))) begin
        hot_line_tag <= 1'b0;
      end
    end
  end
  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 4'h0;
      pos_thr <= `PSS_POS_THR_DEF;
      neg_thr <= `PSS_NEG_THR_DEF;
      t1 <= `PSS_T1_DEF;
      t2 <= `PSS_T2_DEF;
      t3 <= `PSS_T3_DEF;
      irq_mask <= 4'h0;
    end else begin
      if (wr) begin
        case (paddr)
          `PSS_CTRL: ctrl <= {2'b00, pwdata[1:0]};
          `PSS_SEQ_THR: begin
            pos_thr <= clamp(pwdata[6:0], `PSS_POS_THR_MIN, `PSS_POS_THR_MAX);
            neg_thr <= clamp(pwdata[14:8], `PSS_NEG_THR_MIN, `PSS_NEG_THR_MAX);
          end
          `PSS_T1: t1 <= pwdata;
          `PSS_T2: t2 <= pwdata;
          `PSS_T3: t3 <= pwdata;
          `PSS_IRQ_MASK: irq_mask <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end
  // set wins over a write-one-to-clear in the same cycle, so no event is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= ev | (irq_stat & ~((wr && paddr == `PSS_IRQ_STAT) ? pwdata[3:0] : 4'h0));
    end
  end
  assign irq = |(irq_stat & irq_mask);
  wire gated = ctrl[`PSS_CTRL_GATED];
  // inverse when positive sequence is low and negative sequence is high
  wire inv_now = (positive_sequence_voltage < pos_thr) & (negative_sequence_voltage > neg_thr);
  wire dir_now = ~inv_now & (positive_sequence_voltage >= pos_thr);
  // signaling sequencer, one per relay
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_ON = 2'd2;
  reg [1:0] oc_st, dr_st;
  reg [31:0] oc_a, dr_a, oc_h, dr_h, oc_f, dr_f;
  reg [31:0] tick_cnt;
  wire tick = (tick_cnt == TICK_CYC - 1);
  wire oc_trip = ptoc | etoc | des2;
  wire dr_trip = des1 | des2;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
    end
  end
  // both relay sequencers share the tick and the timer settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_st <= ST_IDLE;
      dr_st <= ST_IDLE;
      oc_a <= 32'h00000000;
      dr_a <= 32'h00000000;
      oc_h <= 32'h00000000;
      dr_h <= 32'h00000000;
      oc_f <= 32'h00000000;
      dr_f <= 32'h00000000;
    end else begin
      if (!gated) begin
        oc_st <= ST_IDLE;
        dr_st <= ST_IDLE;
      end else begin
        case (oc_st)
          ST_IDLE: if (oc_trip) begin
            oc_st <= ST_WAIT;
            oc_a <= 32'h00000000;
          end
          ST_WAIT: begin
            // instantaneous voltage condition, no filter
            if (vabs) begin
              oc_st <= ST_ON;
              oc_h <= 32'h00000000;
              oc_f <= 32'h00000000;
            end else if (oc_a >= t1) begin
              oc_st <= ST_IDLE;
            end else if (tick) begin
              oc_a <= oc_a + 32'h00000001;
            end
          end
          ST_ON: begin
            oc_h <= vpres ? (tick ? oc_h + 32'h00000001 : oc_h) : 32'h00000000;
            if (tick) begin
              oc_f <= oc_f + 32'h00000001;
            end
            if (vpres && oc_h >= t2) begin
              oc_st <= ST_IDLE;
            end else if (oc_f >= t3) begin
              oc_st <= ST_IDLE;
            end
          end
          default: oc_st <= ST_IDLE;
        endcase
        case (dr_st)
          ST_IDLE: if (dr_trip) begin
            dr_st <= ST_WAIT;
            dr_a <= 32'h00000000;
          end
          ST_WAIT: begin
            if (vabs) begin
              dr_st <= ST_ON;
              dr_h <= 32'h00000000;
              dr_f <= 32'h00000000;
            end else if (dr_a >= t1) begin
              dr_st <= ST_IDLE;
            end else if (tick) begin
              dr_a <= dr_a + 32'h00000001;
            end
          end
          ST_ON: begin
            dr_h <= vpres ? (tick ? dr_h + 32'h00000001 : dr_h) : 32'h00000000;
            if (tick) begin
              dr_f <= dr_f + 32'h00000001;
            end
            if (vpres && dr_h >= t2) begin
              dr_st <= ST_IDLE;
            end else if (dr_f >= t3) begin
              dr_st <= ST_IDLE;
            end
          end
          default: dr_st <= ST_IDLE;
        endcase
      end
    end
  end
  // relay commands: timer-gated or plain trip-following
  wire next_oc = gated ? (oc_st == ST_ON) : oc_trip;
  wire next_dr = gated ? (dr_st == ST_ON) : dr_trip;
  // rising edges only: inverse rotation, sensor fault, relay commands
  assign ev = {
    inv_now & ~inverse_rotation,
    sfault & ~protection_block,
    next_dr & ~directional_signal_output,
    next_oc & ~overcurrent_signal_output};
  wire [31:0] status_word = {
    20'h00000,
    dr_st,
    oc_st,
    directional_signal_output,
    overcurrent_signal_output,
    protection_block,
    direct_rotation,
    inverse_rotation,
    remote,
    reclose_inhibit,
    hot_line_tag};
  // protection steering follows the tag and the synced block input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensitive_settings <= 1'b0;
      first_shot_settings <= 1'b0;
      reclose_inhibit <= 1'b0;
    end else begin
      sensitive_settings <= hot_line_tag;
      reclose_inhibit <= hot_line_tag | rblk;
      first_shot_settings <= rblk & ~hot_line_tag;
    end
  end
  // rotation indications
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inverse_rotation <= 1'b0;
      direct_rotation <= 1'b0;
      directional_block <= 1'b0;
    end else begin
      inverse_rotation <= inv_now;
      direct_rotation <= dir_now;
      directional_block <= inv_now | sfault;
    end
  end
  // sensor supervision blocks protection but never stops measurement
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_block <= 1'b0;
      voltage_dependent_reclose_off <= 1'b0;
      measurement_enable <= 1'b1;
    end else begin
      protection_block <= sfault;
      voltage_dependent_reclose_off <= sfault;
      measurement_enable <= 1'b1;
    end
  end
  // relays and leds load the same next value, so they cannot drift apart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overcurrent_signal_output <= 1'b0;
      directional_signal_output <= 1'b0;
      overcurrent_led <= 1'b0;
      directional_led <= 1'b0;
    end else begin
      overcurrent_signal_output <= next_oc;
      directional_signal_output <= next_dr;
      overcurrent_led <= next_oc;
      directional_led <= next_dr;
    end
  end
  // one-cycle command pulses for the event log
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overcurrent_cmd_event <= 1'b0;
      directional_cmd_event <= 1'b0;
    end else begin
      overcurrent_cmd_event <= next_oc & ~overcurrent_signal_output;
      directional_cmd_event <= next_dr & ~directional_signal_output;
    end
  end
  // read data is captured in the setup cycle and stands through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      if (rd) begin
        case (paddr)
          `PSS_CTRL: prdata <= {28'h0000000, ctrl};
          `PSS_STATUS: prdata <= status_word;
          `PSS_SEQ_THR: prdata <= {17'h00000, neg_thr, 1'b0, pos_thr};
          `PSS_T1: prdata <= t1;
          `PSS_T2: prdata <= t2;
          `PSS_T3: prdata <= t3;
          `PSS_IRQ_STAT: prdata <= {28'h0000000, irq_stat};
          `PSS_IRQ_MASK: prdata <= {28'h0000000, irq_mask};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // pss_supervision

// File: sim/protection_signal_supervision_test.sv
`timescale 1ns/1ps
module protection_signal_supervision_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, line_dead = 0;
  logic tag_button = 0, remote_mode = 0, tag_command = 0, reclose_block = 0, sensor_fault = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] trip_req = 4'h0, r;
  logic [6:0] positive_sequence_voltage = 7'h32, negative_sequence_voltage = 7'h00;
  wire [31:0] prdata;
  wire pready, pslverr, irq, hot_line_tag, sensitive_settings, first_shot_settings, reclose_inhibit;
  wire directional_block, protection_block, voltage_dependent_reclose_off, measurement_enable;
  wire inverse_rotation, direct_rotation, overcurrent_signal_output, directional_signal_output;
  wire overcurrent_led, directional_led, overcurrent_cmd_event, directional_cmd_event;
  wire phase_time_overcurrent, earth_time_overcurrent, directional_earth_stage_one, directional_earth_stage_two;
  wire voltage_present, voltage_absent;
  int fails = 0, checked = 0, seed = 82, ev = 0, k, n;
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (overcurrent_cmd_event === 1'b1) ev++;
  // short tick keeps the timers within a brief run
  pss_supervision #(.TICK_CYC(4)) dut (.*);
  pss_field_model field (.*);
  task close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) fails++;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task press(input logic cmd);
    if (cmd) tag_command <= 1;
    else tag_button <= 1;
    cyc(4);
    tag_command <= 0;
    tag_button <= 0;
    cyc(4);
  endtask
  function logic [1:0] exp_relays(input logic [3:0] t);
    return {|(t & 4'hB), |(t & 4'hC)};
  endfunction
  initial begin
    #2000000;
    fails++;
    close_out;
  end
  initial begin
    cyc(6);
    presetn <= 1;
    cyc(1);
    chk(measurement_enable, 1);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    chk(pslverr, 0);
    apb(1, 8'h0C, 3);
    apb(1, 8'h10, 5);
    apb(1, 8'h14, 20);
    apb(0, 8'h0C, 0);
    chk(rd, 3);
    press(0);
    chk({hot_line_tag, sensitive_settings, reclose_inhibit, first_shot_settings}, 4'hE);
    press(1);
    chk(hot_line_tag, 1);
    remote_mode <= 1;
    press(0);
    chk(hot_line_tag, 1);
    press(1);
    chk(hot_line_tag, 0);
    apb(1, 8'h00, 4);
    cyc(2);
    chk(hot_line_tag, 1);
    apb(1, 8'h00, 8);
    reclose_block <= 1;
    cyc(4);
    chk({hot_line_tag, sensitive_settings, reclose_inhibit, first_shot_settings}, 4'h3);
    reclose_block <= 0;
    positive_sequence_voltage <= 7'h02;
    negative_sequence_voltage <= 7'h50;
    cyc(4);
    chk({inverse_rotation, direct_rotation, directional_block}, 3'h5);
    positive_sequence_voltage <= 7'h05;
    cyc(4);
    chk({inverse_rotation, direct_rotation, directional_block}, 3'h2);
    sensor_fault <= 1;
    cyc(5);
    chk({protection_block, voltage_dependent_reclose_off, directional_block, measurement_enable}, 4'hF);
    sensor_fault <= 0;
    repeat (4) begin
      r = 4'({$random(seed)} % 15 + 1);
      trip_req <= r;
      cyc(5);
      chk({overcurrent_signal_output, directional_signal_output}, exp_relays(r));
      trip_req <= 0;
      cyc(5);
      chk({overcurrent_signal_output, directional_signal_output}, 0);
    end
    apb(1, 8'h00, 1);
    ev = 0;
    for (k = 0; k < 4; k++) begin
      trip_req <= 4'(1 << k);
      cyc(2 + {$random(seed)} % 5);
      line_dead <= 1;
      trip_req <= 0;
      cyc(8);
      chk({overcurrent_signal_output, directional_signal_output}, exp_relays(4'(1 << k)));
      chk({overcurrent_led, directional_led}, exp_relays(4'(1 << k)));
      line_dead <= 0;
      cyc(12);
      chk({overcurrent_signal_output, directional_signal_output}, exp_relays(4'(1 << k)));
      cyc(30);
      chk({overcurrent_signal_output, directional_signal_output}, 0);
    end
    chk(ev, 3);
    trip_req <= 1;
    cyc(3);
    trip_req <= 0;
    cyc(30);
    line_dead <= 1;
    cyc(8);
    chk(overcurrent_signal_output, 0);
    line_dead <= 0;
    apb(1, 8'h1C, 3);
    trip_req <= 1;
    cyc(3);
    line_dead <= 1;
    trip_req <= 0;
    cyc(30);
    chk({overcurrent_signal_output, irq}, 2'h3);
    apb(1, 8'h1C, 0);
    chk(irq, 0);
    apb(1, 8'h18, 3);
    apb(1, 8'h1C, 3);
    chk(irq, 0);
    cyc(60);
    chk(overcurrent_signal_output, 0);
    close_out;
  end
endmodule // protection_signal_supervision_test

// File: sim/pss_field_model.sv
`timescale 1ns/1ps
module pss_field_model (
  // requests from the bench
  input wire [3:0] trip_req,
  input wire line_dead,
  // trip flags and detectors
  output wire phase_time_overcurrent,
  output wire earth_time_overcurrent,
  output wire directional_earth_stage_one,
  output wire directional_earth_stage_two,
  output wire voltage_present,
  output wire voltage_absent
);
  assign {directional_earth_stage_two, directional_earth_stage_one} = trip_req[3:2];
  assign {earth_time_overcurrent, phase_time_overcurrent} = trip_req[1:0];
  // raw detector levels, no filter delay
  assign voltage_present = !line_dead;
  assign voltage_absent = line_dead;
endmodule // pss_field_model

// File: sim/pss_supervision_assertions.sv
`timescale 1ns/1ps
module pss_checker (
  // clock, reset, cause
  input wire pclk,
  input wire presetn,
  input wire sensor_fault,
  // steering
  input wire hot_line_tag,
  input wire sensitive_settings,
  input wire first_shot_settings,
  input wire reclose_inhibit,
  input wire directional_block,
  input wire protection_block,
  input wire voltage_dependent_reclose_off,
  input wire measurement_enable,
  input wire inverse_rotation,
  input wire direct_rotation,
  // signaling
  input wire overcurrent_signal_output,
  input wire directional_signal_output,
  input wire overcurrent_led,
  input wire directional_led,
  input wire overcurrent_cmd_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // two sync stages plus the output register
  sequence s_fault_held;
    sensor_fault [*4];
  endsequence
  a_tag_sensitive: assert property (sensitive_settings == $past(hot_line_tag)) else $error("tag settings");
  a_tag_inhibit: assert property ($past(hot_line_tag) |-> reclose_inhibit) else $error("tag reclose");
  a_block_first: assert property (first_shot_settings |-> reclose_inhibit && !sensitive_settings) else $error("block");
  a_inverse_blocks: assert property ($rose(inverse_rotation) |-> ##[0:1] directional_block) else $error("inv");
  a_rotation_excl: assert property (!(inverse_rotation && direct_rotation)) else $error("both rotations");
  a_fault_blocks: assert property (s_fault_held |-> protection_block && voltage_dependent_reclose_off) else $error("flt");
  a_measure_kept: assert property (measurement_enable) else $error("measurement stopped");
  a_led_mirror: assert property (overcurrent_led == overcurrent_signal_output &&
    directional_led == directional_signal_output) else $error("led mismatch");
  a_event_pulse: assert property (overcurrent_cmd_event |=> !overcurrent_cmd_event) else $error("event width");
endmodule // pss_checker
bind pss_supervision pss_checker u_chk (.pclk, .presetn, .sensor_fault, .hot_line_tag, .sensitive_settings,
  .first_shot_settings, .reclose_inhibit, .directional_block, .protection_block, .voltage_dependent_reclose_off,
  .measurement_enable, .inverse_rotation, .direct_rotation, .overcurrent_signal_output,
  .directional_signal_output, .overcurrent_led, .directional_led, .overcurrent_cmd_event);
